// File: verilog/adc_seq_ctrl.v
// Converter sequence, result placement and freeze control with AXI4-Lite
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_seq_ctrl #(
  parameter DATA_W = 10,
  parameter DEPTH = 8,
  parameter CNT_W = 3
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire freeze,
  output reg conv_start_q,
  output reg conv_abort_q,
  output reg conv_hold_q,
  input wire conv_done,
  input wire [DATA_W-1:0] conv_data,
  output wire irq
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ = 2'h1;
  localparam [1:0] ST_BUSY = 2'h2;

  // Register state
  reg [7:0] seq_ctrl_q;
  reg scan_q;
  reg fast_clr_q;
  reg [DEPTH-1:0] done_flags_q;
  reg [DEPTH-1:0] done_flags_d;
  reg armed_q;
  reg [1:0] ist_q;
  reg [1:0] ist_d;
  reg [1:0] imask_q;

  // Sequencer state
  reg [1:0] st_q;
  reg [3:0] seq_cnt_q;

  // Bus state
  reg aw_have_q;
  reg w_have_q;
  reg [`ADDR_W-1:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wlane_q;
  reg rd_pend_q;
  reg [`ADDR_W-1:0] araddr_q;

  wire [CNT_W-1:0] pos;
  wire [DATA_W-1:0] mem_rdata;

  // =====================================================================
  // Field views
  wire [3:0] len_code = seq_ctrl_q[`LEN_MSB:`LEN_LSB];
  wire fifo_mode = seq_ctrl_q[`FIFO_BIT];
  wire [1:0] brk_resp = seq_ctrl_q[`BRK_MSB:`BRK_LSB];

  // Sequence length, 8 for code zero or top bit set
  wire [3:0] seq_len = (len_code[3] || len_code == 4'h0) ?
                       4'h8 : len_code;

  // Breakpoint policy; codes 00 and 01 never stop conversion
  wire brk_now = freeze && (brk_resp == `BRK_HALT_NOW);
  wire brk_block = freeze && brk_resp[1];

  // =====================================================================
  // Write channel handshakes
  assign s_axi_awready = ce && !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_have_q && !s_axi_bvalid;
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  // Write decode
  wire wr_res = ((awaddr_q & `RES_REGION_MASK) == `OFS_RES_BASE) &&
                (awaddr_q[1:0] == 2'h0);
  wire wr_seq = (awaddr_q == `OFS_SEQ_CTRL);
  wire wr_start = (awaddr_q == `OFS_START);
  wire wr_ctrl2 = (awaddr_q == `OFS_CTRL2);
  wire wr_known = wr_seq || wr_start || wr_ctrl2 || wr_res ||
                  awaddr_q == `OFS_STATUS0 || awaddr_q == `OFS_FLAGS ||
                  awaddr_q == `OFS_IRQ_STAT || awaddr_q == `OFS_IRQ_MASK;
  wire wr_eff = wr_fire && wlane_q;

  // Control writes abort; the start register alone also begins
  wire ctl_wr = wr_eff && (wr_seq || wr_start || wr_ctrl2);
  wire begin_seq = wr_eff && wr_start;

  // =====================================================================
  // Read channel handshakes and decode
  assign s_axi_arready = ce && !rd_pend_q && !s_axi_rvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rd_res = ((s_axi_araddr & `RES_REGION_MASK) == `OFS_RES_BASE) &&
                (s_axi_araddr[1:0] == 2'h0);
  wire rd_flags = (s_axi_araddr == `OFS_FLAGS);
  wire [CNT_W-1:0] rd_idx = s_axi_araddr[CNT_W+1:2];
  wire [CNT_W-1:0] wr_idx = awaddr_q[CNT_W+1:2];

  // =====================================================================
  // Conversion completion bookkeeping
  wire take = (st_q == ST_BUSY) && conv_done && !ctl_wr;
  wire [3:0] seq_next = seq_cnt_q + 4'h1;
  wire seq_end = take && (seq_next == seq_len);

  // Counter clears: control write always, sequence edges outside FIFO
  wire pos_clear = ctl_wr || (seq_end && !fifo_mode);
  wire pos_adv = take;

  conv_counter #(
    .CNT_W(CNT_W),
    .DEPTH(DEPTH)
  ) u_pos (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clear(pos_clear),
    .advance(pos_adv),
    .count_q(pos)
  );

  result_mem #(
    .DATA_W(DATA_W),
    .DEPTH(DEPTH),
    .IDX_W(CNT_W)
  ) u_mem (
    .aclk(aclk),
    .ce(ce),
    .we(take),
    .waddr(pos),
    .wdata(conv_data),
    .re(rd_fire && rd_res),
    .raddr(rd_idx),
    .rdata_q(mem_rdata)
  );

  // =====================================================================
  // Write address and data capture, either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {`ADDR_W{1'b0}};
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // =====================================================================
  // Software registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_ctrl_q <= `SEQ_CTRL_RST;
      scan_q <= 1'b0;
      fast_clr_q <= 1'b0;
      imask_q <= 2'h0;
    end
    else if (ce && wr_eff)
    begin
      if (wr_seq)
        seq_ctrl_q <= {1'b0, wdata_q[6:0]};
      if (wr_start)
        scan_q <= wdata_q[`SCAN_BIT];
      if (wr_ctrl2)
        fast_clr_q <= wdata_q[`FAST_CLR_BIT];
      if (awaddr_q == `OFS_IRQ_MASK)
        imask_q <= wdata_q[1:0];
    end
  end

  // =====================================================================
  // Complete flags: set wins over any clear in the same cycle
  always @*
  begin
    done_flags_d = done_flags_q;
    if (rd_fire && rd_res && (fast_clr_q || armed_q))
      done_flags_d[rd_idx] = 1'b0;
    if (wr_eff && wr_res && fast_clr_q)
      done_flags_d[wr_idx] = 1'b0;
    if (take)
      done_flags_d[pos] = 1'b1;
  end

  // Flag storage and normal clear arming by a flags read
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_flags_q <= {DEPTH{1'b0}};
      armed_q <= 1'b0;
    end
    else if (ce)
    begin
      done_flags_q <= done_flags_d;
      if (rd_fire && rd_flags)
        armed_q <= 1'b1;
      else if (rd_fire && rd_res)
        armed_q <= 1'b0;
    end
  end

  // =====================================================================
  // Interrupt status, write one to clear, events win
  always @*
  begin
    ist_d = ist_q;
    if (wr_eff && awaddr_q == `OFS_IRQ_STAT)
      ist_d = ist_q & ~wdata_q[1:0];
    if (seq_end)
      ist_d[`IRQ_SEQ_BIT] = 1'b1;
    if (take)
      ist_d[`IRQ_CONV_BIT] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      ist_q <= 2'h0;
    else if (ce)
      ist_q <= ist_d;
  end

  assign irq = |(ist_q & imask_q);

  // =====================================================================
  // Sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      seq_cnt_q <= 4'h0;
      conv_start_q <= 1'b0;
      conv_abort_q <= 1'b0;
      conv_hold_q <= 1'b0;
    end
    else if (ce)
    begin
      conv_start_q <= 1'b0;
      conv_abort_q <= ctl_wr && (st_q != ST_IDLE);
      conv_hold_q <= brk_now && (st_q == ST_BUSY);
      if (ctl_wr)
      begin
        seq_cnt_q <= 4'h0;
        st_q <= begin_seq ? ST_REQ : ST_IDLE;
      end
      else
      begin
        case (st_q)
          ST_IDLE:
            st_q <= ST_IDLE;
          ST_REQ:
          begin
            // No new conversion is started while frozen with breakpoint code 10 or 11
            if (!brk_block)
            begin
              conv_start_q <= 1'b1;
              st_q <= ST_BUSY;
            end
          end
          ST_BUSY:
          begin
            if (take)
            begin
              if (seq_end)
              begin
                seq_cnt_q <= 4'h0;
                st_q <= scan_q ? ST_REQ : ST_IDLE;
              end
              else
              begin
                seq_cnt_q <= seq_next;
                st_q <= ST_REQ;
              end
            end
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // Read data path, one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend_q <= 1'b0;
      araddr_q <= {`ADDR_W{1'b0}};
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        rd_pend_q <= 1'b1;
        araddr_q <= s_axi_araddr;
      end
      else if (rd_pend_q)
      begin
        rd_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (((araddr_q & `RES_REGION_MASK) == `OFS_RES_BASE) &&
            (araddr_q[1:0] == 2'h0))
          s_axi_rdata[DATA_W-1:0] <= mem_rdata;
        else
        begin
          case (araddr_q)
            `OFS_SEQ_CTRL:
              s_axi_rdata[7:0] <= seq_ctrl_q;
            `OFS_START:
              s_axi_rdata[`SCAN_BIT] <= scan_q;
            `OFS_STATUS0:
            begin
              s_axi_rdata[CNT_W-1:0] <= pos;
              s_axi_rdata[`BUSY_BIT] <= (st_q != ST_IDLE);
            end
            `OFS_FLAGS:
              s_axi_rdata[DEPTH-1:0] <= done_flags_q;
            `OFS_CTRL2:
              s_axi_rdata[`FAST_CLR_BIT] <= fast_clr_q;
            `OFS_IRQ_STAT:
              s_axi_rdata[1:0] <= ist_q;
            `OFS_IRQ_MASK:
              s_axi_rdata[1:0] <= imask_q;
            default:
              s_axi_rresp <= `RESP_SLVERR;
          endcase
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // adc_seq_ctrl

// File: include/adc_seq_consts.vh
// Constants for the converter sequence and result control block
//
// Overview of operation
// - A sequence control write aborts a running sequence, starts none.
// - Length 0000 is 8, 0001-0111 are 1-7, any code with bit 3 set is 8.
// - Reset sets only length bit 2, giving four conversions.
// - Outside FIFO mode conversion n lands in result register n.
// - In FIFO mode sequence end and scan restart leave the counter as it is.
// - In FIFO mode the counter wraps to register zero after the last.
// - A status field shows the counter, the next result slot.
// - A control write abort or start clears the counter, even in FIFO mode.
// - Each result register has a complete flag, set when it gets a result.
// - Breakpoint code 00 runs on, 10 finishes then halts, 11 halts at once.
// - With fast flag clear on, a result register access clears its flag.
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// =====================================================================
// Register byte offsets
`define ADDR_W 8
`define OFS_SEQ_CTRL 8'h00
`define OFS_START 8'h04
`define OFS_STATUS0 8'h08
`define OFS_FLAGS 8'h0c
`define OFS_CTRL2 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_RES_BASE 8'h20
`define RES_REGION_MASK 8'he0

// =====================================================================
// Field positions
`define LEN_MSB 6
`define LEN_LSB 3
`define FIFO_BIT 2
`define BRK_MSB 1
`define BRK_LSB 0
`define SCAN_BIT 0
`define FAST_CLR_BIT 0
`define BUSY_BIT 7
`define IRQ_SEQ_BIT 0
`define IRQ_CONV_BIT 1

// =====================================================================
// Reset values and codes
`define SEQ_CTRL_RST 8'h20
`define BRK_HALT_AFTER 2'h2
`define BRK_HALT_NOW 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/result_mem.v
// Result register file with registered read port
`timescale 1ns/1ps
module result_mem #(
  parameter DATA_W = 10,
  parameter DEPTH = 8,
  parameter IDX_W = 3
)(
  input wire aclk,
  input wire ce,
  input wire we,
  input wire [IDX_W-1:0] waddr,
  input wire [DATA_W-1:0] wdata,
  input wire re,
  input wire [IDX_W-1:0] raddr,
  output reg [DATA_W-1:0] rdata_q
);

  reg [DATA_W-1:0] mem [0:DEPTH-1];

  // =====================================================================
  // Storage and read register
  always @(posedge aclk)
  begin
    if (ce)
    begin
      if (we)
        mem[waddr] <= wdata;
      if (re)
        rdata_q <= mem[raddr];
    end
  end

endmodule // result_mem

// File: verilog/conv_counter.v
// Result position counter with clear and wrap
`timescale 1ns/1ps
module conv_counter #(
  parameter CNT_W = 3,
  parameter DEPTH = 8
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire clear,
  input wire advance,
  output reg [CNT_W-1:0] count_q
);

  localparam integer LAST = DEPTH - 1;

  // =====================================================================
  // Clear has priority over advance
  always @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= {CNT_W{1'b0}};
    else if (ce)
    begin
      if (clear)
        count_q <= {CNT_W{1'b0}};
      else if (advance)
      begin
        if (count_q == LAST[CNT_W-1:0])
          count_q <= {CNT_W{1'b0}};
        else
          count_q <= count_q + 1'b1;
      end
    end
  end

endmodule // conv_counter

// File: dv/adc_seq_ctrl_monitor.sv
// Port-level checks for the sequence control block
`timescale 1ns/1ps
module adc_seq_ctrl_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire freeze,
  input wire conv_start_q,
  input wire conv_abort_q,
  input wire conv_hold_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==================================================================
  // Bus answers
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |->
    ##2 s_axi_rvalid) else $error("read answer not on time");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during answer");

  // ==================================================================
  // Converter control
  a_abort_cause: assert property (conv_abort_q |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("abort without a register write");
  a_abort_pulse: assert property (conv_abort_q |=> !conv_abort_q)
    else $error("abort longer than one cycle");
  a_start_pulse: assert property (conv_start_q |=> !conv_start_q)
    else $error("start longer than one cycle");
  a_hold_cause: assert property (conv_hold_q |-> $past(freeze))
    else $error("hold without breakpoint");
  a_hold_nostart: assert property (conv_hold_q |-> !conv_start_q)
    else $error("start while halted");
endmodule // adc_seq_ctrl_monitor

bind adc_seq_ctrl adc_seq_ctrl_monitor u_adc_seq_ctrl_monitor (.aclk,
  .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .freeze,
  .conv_start_q, .conv_abort_q, .conv_hold_q);

// File: dv/test_adc_sequence_result_control.sv
// Self-checking bench for the sequence control block
`timescale 1ns/1ps
module test_adc_sequence_result_control;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg ce = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, freeze = 1'b0;
  reg conv_done = 1'b0;
  reg [9:0] conv_data = 10'h000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, conv_start_q, conv_abort_q;
  wire conv_hold_q, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_mismatch = 0, samples_checked = 0;
  integer budget = 0, ndone = 0, nstart = 0, nabort = 0, base, n0, i, n;
  reg [31:0] rd_q;
  reg [1:0] resp_q;
  reg [3:0] code;

  adc_seq_ctrl u_adc_seq_ctrl (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .freeze,
    .conv_start_q, .conv_abort_q, .conv_hold_q, .conv_done, .conv_data,
    .irq);

  // Clock, 40 ns period
  always #20 aclk = ~aclk;

  // Converter stand-in: answers starts until ndone reaches budget
  always @(posedge aclk)
  begin
    conv_done <= 1'b0;
    if (conv_abort_q === 1'b1)
      nabort <= nabort + 1;
    if (conv_start_q === 1'b1)
    begin
      nstart <= nstart + 1;
      if (ndone < budget)
      begin
        conv_done <= 1'b1;
        conv_data <= 10'h100 + ndone[9:0];
        ndone <= ndone + 1;
      end
    end
  end

  // ==================================================================
  // Shared tasks
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) break;
      end
      resp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) break;
      end
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  // Waits a bounded time for the interrupt line
  task wait_irq;
    integer k;
    begin
      k = 0;
      while (irq !== 1'b1 && k < 300)
      begin
        @(posedge aclk);
        k = k + 1;
      end
      chk("irq raised", 1, irq);
    end
  endtask

  // ==================================================================
  // Scenarios
  task t_reset;
    begin
      rd(8'h00);
      chk("seq ctrl reset", 32'h20, rd_q);
      rd(8'h08);
      chk("status reset", 32'h0, rd_q);
    end
  endtask

  // Clock enable low holds the bus and all state
  task t_ce;
    begin
      ce <= 1'b0;
      fork
        rd(8'h00);
        begin
          repeat (8) @(posedge aclk);
          chk("arready frozen", 0, s_axi_arready);
          chk("rvalid frozen", 0, s_axi_rvalid);
          ce <= 1'b1;
        end
      join
      chk("seq ctrl held", 32'h20, rd_q);
    end
  endtask

  // Every length class, results in fixed slots, complete flags
  task t_length;
    begin
      wr(8'h18, 32'h1);
      for (i = 0; i < 5; i = i + 1)
      begin
        code = 4'(20'hf8710 >> (i * 4));
        n = (code == 4'h0 || code[3]) ? 8 : code;
        wr(8'h00, {25'h0, code, 3'b000});
        base = ndone;
        budget <= ndone + 20;
        wr(8'h04, 32'h0);
        wait_irq;
        chk("conversions", n, ndone - base);
        budget <= ndone;
        rd(8'h0c);
        chk("complete flag", 1, rd_q[n-1]);
        rd(8'(8'h20 + 4 * (n - 1)));
        chk("last result", 32'h100 + base + n - 1, rd_q);
        rd(8'h08);
        chk("counter at end", 32'h0, rd_q);
        wr(8'h14, 32'h1);
        chk("irq cleared", 0, irq);
      end
    end
  endtask

  // FIFO placement across scans, wrap, masked irq, abort by write
  task t_fifo;
    integer k;
    begin
      wr(8'h18, 32'h0);
      wr(8'h00, 32'h1c);
      base = ndone;
      budget <= ndone + 10;
      wr(8'h04, 32'h1);
      for (k = 0; k < 300 && ndone < base + 10; k = k + 1) @(posedge aclk);
      repeat (5) @(posedge aclk);
      chk("irq masked", 0, irq);
      rd(8'h14);
      chk("irq status", 1, rd_q[0]);
      rd(8'h08);
      chk("fifo counter", 32'h82, rd_q);
      rd(8'h24);
      chk("wrapped result", 32'h100 + base + 9, rd_q);
      n = nabort;
      wr(8'h00, 32'h1c);
      n0 = nstart;
      rd(8'h08);
      chk("counter cleared", 32'h0, rd_q);
      chk("abort pulse", n + 1, nabort);
      repeat (20) @(posedge aclk);
      chk("no restart", n0, nstart);
      wr(8'h14, 32'h3);
      wr(8'h18, 32'h1);
    end
  endtask

  // Breakpoint codes 11, 10, 00 and 01
  task t_freeze;
    begin
      budget <= ndone;
      wr(8'h00, 32'h0b);
      wr(8'h04, 32'h0);
      repeat (3) @(posedge aclk);
      freeze <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("hold on", 1, conv_hold_q);
      freeze <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("hold off", 0, conv_hold_q);
      wr(8'h00, 32'h0a);
      freeze <= 1'b1;
      n0 = nstart;
      wr(8'h04, 32'h0);
      repeat (10) @(posedge aclk);
      chk("start withheld", n0, nstart);
      budget <= ndone + 1;
      freeze <= 1'b0;
      wait_irq;
      wr(8'h14, 32'h1);
      for (i = 0; i < 2; i = i + 1)
      begin
        wr(8'h00, 32'h08 | i);
        freeze <= 1'b1;
        base = ndone;
        budget <= ndone + 1;
        wr(8'h04, 32'h0);
        wait_irq;
        chk("runs in breakpoint", 1, ndone - base);
        chk("no hold", 0, conv_hold_q);
        freeze <= 1'b0;
        wr(8'h14, 32'h1);
      end
    end
  endtask

  // Fast flag clear on read and write, unmapped addresses
  task t_fast;
    begin
      wr(8'h10, 32'h1);
      rd(8'h0c);
      chk("flags before", 2'b11, rd_q[1:0]);
      rd(8'h20);
      wr(8'h24, 32'h0);
      chk("ro write resp", 2'h0, resp_q);
      rd(8'h0c);
      chk("flags after", 2'b00, rd_q[1:0]);
      wr(8'h10, 32'h0);
      rd(8'h40);
      chk("unmapped read", 2'h2, resp_q);
      wr(8'h41, 32'h0);
      chk("unaligned write", 2'h2, resp_q);
    end
  endtask

  // ==================================================================
  // Verdict and run control
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #2000000;
    $display("unexpected watchdog: expected done, seen hang");
    n_mismatch = n_mismatch + 1;
    stop_test;
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_ce;
    t_length;
    t_fifo;
    t_freeze;
    t_fast;
    stop_test;
  end
endmodule // test_adc_sequence_result_control
